// file: pkg/srs_consts.svh
// Timing counts and peripheral count for the staged reset release.
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_POR_EXT_CYC  64
`define SRS_SYNC_RST_CYC 3
`define SRS_CLKGEN_CYC   32
`define SRS_PERIPH_CYC   32
`define SRS_CORE_CYC     32
`define SRS_NUM_PERIPH   8
`endif

// file: pkg/srs_pkg.sv
// Types shared by the startup reset sequencer.
package srs_pkg;
    typedef enum logic [1:0] {
        SRS_MODE_RUN,
        SRS_MODE_WAIT,
        SRS_MODE_STOP
    } srs_mode_t;
endpackage

// file: design/srs_stage_ext.sv
// One reset stretching stage: releases after a set count of ticks.
`timescale 1ns/1ps
module srs_stage_ext
    import srs_pkg::*;
#(
    parameter int CNT = 32
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic clk_en,
    input  wire logic hold,
    input  wire logic tick,
    output logic      released
);
    localparam int CW = $clog2(CNT + 1);
    localparam logic [CW-1:0] LAST = CW'(CNT - 1);

    logic [CW-1:0] cnt_ff;
    logic          done_ff;

    // Counting starts once hold drops; any new hold clears it at once.
    always_ff @(posedge mclk) begin
        if (srst || (clk_en && hold)) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else if (clk_en && tick && !done_ff) begin
            if (cnt_ff == LAST) begin
                done_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end

    assign released = done_ff;
endmodule

// file: design/srs_top.sv
// Startup reset sequencer with staged release and power mode gating.
`timescale 1ns/1ps
`include "srs_consts.svh"

module srs_top
    import srs_pkg::*;
#(
    parameter int NPER       = `SRS_NUM_PERIPH,
    parameter int POR_CYC    = `SRS_POR_EXT_CYC,
    parameter int SYNC_CYC   = `SRS_SYNC_RST_CYC,
    parameter int CLKGEN_CYC = `SRS_CLKGEN_CYC,
    parameter int PERIPH_CYC = `SRS_PERIPH_CYC,
    parameter int CORE_CYC   = `SRS_CORE_CYC
) (
    input  wire logic            mclk,
    input  wire logic            srst,
    input  wire logic            clk_en,
    input  wire logic            por_n,
    input  wire logic            ext_rst_n,
    input  wire logic            watchdog_reset_source_n,
    input  wire logic            sw_rst_n,
    input  wire logic            sys_tick,
    input  wire logic            wait_req,
    input  wire logic            stop_req,
    input  wire logic            irq_any,
    input  wire logic [NPER-1:0] periph_irq,
    input  wire logic            lvi_irq,
    input  wire logic            debug_req,
    input  wire logic [NPER-1:0] stop_disable_registers,
    output logic                 extended_por_rst,
    output logic                 combined_rst,
    output logic                 sys_rst_n,
    output logic                 sync_rst,
    output logic                 clock_generator_reset,
    output logic                 peripheral_reset,
    output logic                 core_reset,
    output logic                 core_clk_en,
    output logic [NPER-1:0]      periph_clk_en,
    output srs_mode_t            pwr_mode
);
    logic      por_meta_ff;
    logic      por_ok_ff;
    logic      ext_meta_ff;
    logic      ext_ok_ff;
    logic      por_done;
    logic      sync_done;
    logic      cg_done;
    logic      per_done;
    logic      core_done;
    logic      cg_rst_ff;
    logic      per_rst_ff;
    logic      core_rst_ff;
    logic      core_clk_ff;
    logic [NPER-1:0] per_clk_ff;
    srs_mode_t mode_ff;
    srs_mode_t nxt_mode;

    // Delays and depths of the power-on and clock generator checks follow the stage counts.
    localparam int POR_LAST = POR_CYC - 1;
    localparam int CG_LATE  = CLKGEN_CYC + 1;

    // Two-stage synchronisers for the raw power-on and external pins.
    always_ff @(posedge mclk) begin
        if (srst) begin
            por_meta_ff <= 1'b0;
            por_ok_ff   <= 1'b0;
            ext_meta_ff <= 1'b0;
            ext_ok_ff   <= 1'b0;
        end else if (clk_en) begin
            por_meta_ff <= por_n;
            por_ok_ff   <= por_meta_ff;
            ext_meta_ff <= ext_rst_n;
            ext_ok_ff   <= ext_meta_ff;
        end
    end

    // The power-on extender only sees the synchronised power-on reset.
    srs_stage_ext #(.CNT(POR_CYC)) u_por_ext (
        .mclk     (mclk),
        .srst     (srst),
        .clk_en   (clk_en),
        .hold     (!por_ok_ff),
        .tick     (1'b1),
        .released (por_done)
    );

    // Combined reset and its active-low twin.
    assign extended_por_rst = !por_done;
    assign sys_rst_n = por_done & ext_ok_ff & watchdog_reset_source_n
                     & sw_rst_n;
    assign combined_rst = extended_por_rst | !ext_ok_ff
                        | !watchdog_reset_source_n | !sw_rst_n;

    // Stages fed by the combined reset release.
    srs_stage_ext #(.CNT(SYNC_CYC)) u_sync_gen (
        .mclk     (mclk),
        .srst     (srst),
        .clk_en   (clk_en),
        .hold     (combined_rst),
        .tick     (1'b1),
        .released (sync_done)
    );

    srs_stage_ext #(.CNT(CLKGEN_CYC)) u_cg_ext (
        .mclk     (mclk),
        .srst     (srst),
        .clk_en   (clk_en),
        .hold     (combined_rst),
        .tick     (1'b1),
        .released (cg_done)
    );

    // Later stages count system clock ticks.
    srs_stage_ext #(.CNT(PERIPH_CYC)) u_per_ext (
        .mclk     (mclk),
        .srst     (srst),
        .clk_en   (clk_en),
        .hold     (cg_rst_ff | combined_rst),
        .tick     (sys_tick),
        .released (per_done)
    );

    srs_stage_ext #(.CNT(CORE_CYC)) u_core_ext (
        .mclk     (mclk),
        .srst     (srst),
        .clk_en   (clk_en),
        .hold     (per_rst_ff | combined_rst),
        .tick     (sys_tick),
        .released (core_done)
    );

    assign sync_rst = !sync_done;

    // Downstream resets change on the falling edge to avoid skew.
    always_ff @(negedge mclk) begin
        if (srst) begin
            cg_rst_ff   <= 1'b1;
            per_rst_ff  <= 1'b1;
            core_rst_ff <= 1'b1;
        end else if (clk_en) begin
            cg_rst_ff   <= !cg_done;
            per_rst_ff  <= !per_done;
            core_rst_ff <= !core_done;
        end
    end

    assign clock_generator_reset = cg_rst_ff;
    assign peripheral_reset      = per_rst_ff;
    assign core_reset            = core_rst_ff;

    // Power mode selection from core requests and wakeup events.
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            SRS_MODE_RUN: begin
                if (stop_req) begin
                    nxt_mode = SRS_MODE_STOP;
                end else if (wait_req) begin
                    nxt_mode = SRS_MODE_WAIT;
                end
            end
            SRS_MODE_WAIT: begin
                if (irq_any || debug_req) begin
                    nxt_mode = SRS_MODE_RUN;
                end
            end
            SRS_MODE_STOP: begin
                if ((|(periph_irq & stop_disable_registers)) || lvi_irq
                    || debug_req) begin
                    nxt_mode = SRS_MODE_RUN;
                end
            end
            default: nxt_mode = SRS_MODE_RUN;
        endcase
    end

    // Any reset returns the mode to run.
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_ff <= SRS_MODE_RUN;
        end else if (clk_en) begin
            if (combined_rst || core_rst_ff) begin
                mode_ff <= SRS_MODE_RUN;
            end else begin
                mode_ff <= nxt_mode;
            end
        end
    end

    // Group clock enables, with per-peripheral stop overrides.
    always_ff @(posedge mclk) begin
        if (srst) begin
            core_clk_ff <= 1'b0;
            per_clk_ff  <= '0;
        end else if (clk_en) begin
            core_clk_ff <= !cg_rst_ff
                         && (mode_ff == SRS_MODE_RUN);
            for (int i = 0; i < NPER; i++) begin
                per_clk_ff[i] <= !cg_rst_ff
                    && ((mode_ff != SRS_MODE_STOP)
                        || stop_disable_registers[i]);
            end
        end
    end

    assign core_clk_en   = core_clk_ff;
    assign periph_clk_en = per_clk_ff;
    assign pwr_mode      = mode_ff;

    // Checks on the sequence, valid while the clock enable stays high.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !clk_en);

    a_comb_or: assert property (
        combined_rst == (extended_por_rst || !ext_ok_ff
            || !watchdog_reset_source_n || !sw_rst_n))
        else $error("combined reset is not the OR of its sources");

    a_sysrst_and: assert property (
        sys_rst_n == !combined_rst)
        else $error("system reset low disagrees with combined reset");

    a_comb_holds: assert property (
        combined_rst |=> clock_generator_reset && sync_rst
            && peripheral_reset && core_reset)
        else $error("a stage is out of reset while combined is set");

    a_por_stretch: assert property (
        $rose(por_ok_ff) |-> extended_por_rst ##POR_LAST
            (extended_por_rst || !por_ok_ff))
        else $error("extended power-on reset released too early");

    a_sync_three: assert property (
        $fell(combined_rst) |-> sync_rst[*3] ##1
            (!sync_rst || combined_rst))
        else $error("watchdog/software reset not released after three");

    a_cg_release: assert property (
        $fell(clock_generator_reset) |->
            !$past(combined_rst, CLKGEN_CYC) && $past(combined_rst, CG_LATE))
        else $error("clock generator reset released at wrong cycle");

    a_per_order: assert property (
        !peripheral_reset |-> !clock_generator_reset)
        else $error("peripheral reset released before clock reset");

    a_core_last: assert property (
        !core_reset |-> !peripheral_reset && !sync_rst)
        else $error("core reset released out of order");

    a_wait_gate: assert property (
        (mode_ff == SRS_MODE_WAIT) |=> !core_clk_en)
        else $error("core clock running in wait");

    a_stop_gate: assert property (
        (mode_ff == SRS_MODE_STOP) |=>
            periph_clk_en == ($past(stop_disable_registers)
                & {NPER{!$past(cg_rst_ff)}}))
        else $error("peripheral clocks wrong in stop");

    c_full_release: cover property ($fell(core_reset));
    c_wait_exit: cover property (
        (mode_ff == SRS_MODE_WAIT) ##1 (mode_ff == SRS_MODE_RUN));
    c_stop_exit: cover property (
        (mode_ff == SRS_MODE_STOP) ##1 (mode_ff == SRS_MODE_RUN));
    c_restart: cover property (!peripheral_reset ##1 combined_rst);
endmodule

// file: bench/srs_far_model.sv
// Behavioural clock generator that supplies system clock ticks.
`timescale 1ns/1ps
module srs_far_model (
    input  wire logic mclk,
    input  wire logic clock_generator_reset,
    input  wire logic slow,
    output logic      sys_tick
);
    logic phase_ff = 1'b0;

    // Phase toggles each oscillator cycle to halve the tick rate when slow.
    always_ff @(posedge mclk) begin
        phase_ff <= ~phase_ff;
    end

    // The generator is silent while it is held in reset.
    assign sys_tick = !clock_generator_reset && (!slow || phase_ff);
endmodule

// file: bench/srs_top_tb.sv
// Self-checking testbench for the startup reset sequencer.
`timescale 1ns/1ps
module srs_top_tb;
    import srs_pkg::*;
    localparam int POR = 8, SYNC = 3, CLKG = 6, PER = 5, CORE = 4;
    logic mclk = 0, srst = 1, por_n = 0, ext_n = 1, wd_n = 1, sw_n = 1;
    logic wait_req = 0, stop_req = 0, irq_any = 0, lvi = 0, dbg = 0;
    logic en = 1;
    logic slow = 0, sys_tick, ext_por, comb, sys_rst_n, sync_rst;
    logic cgr, prst, crst, core_ce;
    logic [7:0] pirq = 8'h00, sdis = 8'h00, pce;
    srs_mode_t  mode;
    int num_errors = 0, comparisons = 0, cyc = 0;
    longint t_por, t_e, t_c, t_s, t_g, t_p, t_k;

    // Free-running oscillator clock.
    always #25 mclk = ~mclk;

    srs_top #(.POR_CYC(POR), .SYNC_CYC(SYNC), .CLKGEN_CYC(CLKG),
              .PERIPH_CYC(PER), .CORE_CYC(CORE)) i_srs_top (
        .mclk(mclk), .srst(srst), .clk_en(en), .por_n(por_n),
        .ext_rst_n(ext_n), .watchdog_reset_source_n(wd_n),
        .sw_rst_n(sw_n), .sys_tick(sys_tick), .wait_req(wait_req),
        .stop_req(stop_req), .irq_any(irq_any), .periph_irq(pirq),
        .lvi_irq(lvi), .debug_req(dbg), .stop_disable_registers(sdis),
        .extended_por_rst(ext_por), .combined_rst(comb),
        .sys_rst_n(sys_rst_n), .sync_rst(sync_rst),
        .clock_generator_reset(cgr), .peripheral_reset(prst),
        .core_reset(crst), .core_clk_en(core_ce),
        .periph_clk_en(pce), .pwr_mode(mode));

    srs_far_model i_srs_far_model (.mclk(mclk),
        .clock_generator_reset(cgr), .slow(slow), .sys_tick(sys_tick));

    // Release instants of every reset, kept for timing comparisons.
    always @(posedge por_n) t_por = $time;
    always @(negedge ext_por) t_e = $time;
    always @(negedge comb) t_c = $time;
    always @(negedge sync_rst) t_s = $time;
    always @(negedge cgr) t_g = $time;
    always @(negedge prst) t_p = $time;
    always @(negedge crst) t_k = $time;

    // Cuts a hung run short well past the expected length.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Waits for the core release, then checks every stage interval after the combined release.
    task automatic run_seq(input logic s);
        int k;
        int d;
        int h;
        k = s ? 2 : 1;
        slow = s;
        for (int i = 0; i < 3000 && crst !== 1'b0; i++) @(negedge mclk);
        // A source freed between rising edges is counted half a cycle on.
        h = (t_c % 50 == 0) ? 25 : 0;
        chk(32'(t_s - t_c + h), 32'(SYNC * 50));
        chk(32'(t_g - t_c + h), 32'(CLKG * 50 + 25));
        chk(32'(t_g % 50), 32'h0);
        d = int'((t_p - t_g) / 50);
        chk(32'(d >= k * PER - k + 1 && d <= k * PER + k), 32'h1);
        d = int'((t_k - t_p) / 50);
        chk(32'(d >= k * CORE - k + 1 && d <= k * CORE + k), 32'h1);
        chk(32'(t_p % 50 + t_k % 50), 32'h0);
        repeat (3) @(negedge mclk);
        chk({core_ce, pce, 6'(mode)}, {9'h1ff, 6'(SRS_MODE_RUN)});
    endtask

    // Asserts one source and expects every stage after the power-on extender back in reset.
    task automatic hit(input int s);
        ext_n = (s != 0);
        wd_n = (s != 1);
        sw_n = (s != 2);
        repeat (4) @(negedge mclk);
        chk({comb, sys_rst_n}, 2'b10);
        chk({sync_rst, cgr, prst, crst, core_ce}, 5'h1e);
        {ext_n, wd_n, sw_n} = 3'b111;
    endtask

    // Aborts a staged release midway, then lets it finish.
    task automatic src_test(input int s);
        hit(s);
        for (int i = 0; i < 300 && cgr !== 1'b0; i++) @(negedge mclk);
        hit(s);
        run_seq(s == 1);
    endtask

    // Pulses one power-mode request or wakeup and checks the clock gates.
    task automatic pm(input int s, input srs_mode_t m, input logic ce,
                      input logic [7:0] pe);
        case (s)
            0: wait_req = 1;
            1: stop_req = 1;
            2: irq_any = 1;
            3: pirq = 8'h02;
            4: pirq = 8'h04;
            5: lvi = 1;
            default: dbg = 1;
        endcase
        @(negedge mclk);
        {wait_req, stop_req, irq_any, lvi, dbg, pirq} = 13'h0;
        repeat (3) @(negedge mclk);
        chk({6'(mode), core_ce, pe ^ pce}, {6'(m), ce, 8'h00});
    endtask

    // Holds the clock enable low; a wait request must not change the mode.
    task automatic frz();
        en = 0;
        wait_req = 1;
        repeat (3) @(negedge mclk);
        chk({6'(mode), core_ce, pce}, {6'(SRS_MODE_RUN), 9'h1ff});
        wait_req = 0;
        en = 1;
        @(negedge mclk);
    endtask

    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge mclk);
        srst = 0;
        repeat (3) @(negedge mclk);
        por_n = 1;
        run_seq(0);
        // Two synchroniser stages come before the extension count.
        d_por: chk(32'(t_e - t_por), 32'(POR * 50 + 75));
        chk(32'(t_g - t_por), 32'((POR + CLKG) * 50 + 100));
        sdis = 8'h05;
        pm(0, SRS_MODE_WAIT, 0, 8'hff);
        pm(2, SRS_MODE_RUN, 1, 8'hff);
        pm(1, SRS_MODE_STOP, 0, 8'h05);
        pm(3, SRS_MODE_STOP, 0, 8'h05);
        pm(4, SRS_MODE_RUN, 1, 8'hff);
        pm(1, SRS_MODE_STOP, 0, 8'h05);
        pm(5, SRS_MODE_RUN, 1, 8'hff);
        pm(1, SRS_MODE_STOP, 0, 8'h05);
        pm(6, SRS_MODE_RUN, 1, 8'hff);
        frz();
        pm(0, SRS_MODE_WAIT, 0, 8'hff);
        pm(6, SRS_MODE_RUN, 1, 8'hff);
        pm(1, SRS_MODE_STOP, 0, 8'h05);
        for (int s = 0; s < 3; s++) src_test(s);
        summarize();
    end
endmodule
